// File: rtl/sccfg_top.sv
// Purpose: Configuration and diagnostic logic of the secondary cache controller
// Assumes: Host cycle strobes are synchronous; tag RAM data arrives on pins
// Notes:   Registers reached over Avalon-MM, one 32-bit word per register
// Summary of operation
// - Mode bits 5:4 pick write burst timing 2-1-1-1, 3-2-2-2 or 4-2-2-2.
// - Mode bits 7:6 pick read burst timing 2-1-1-1, 2-2-2-2 or 3-2-2-2.
// - SRAM test bit suppresses DRAM CAS for cycles inside the test window.
// - Diag bit 1 enables tag test mode; bits 2 and 5:4 reserved.
// - Window select clear: 40000h-7FFFFh, or 20000h-9FFFFh for 512K.
// - Window select set: 100000h-1FFFFFh for every cache size.
// - Diag bits 7:6 limit line fills to code, data, or both.
// - Fill limit leaves hit servicing and L1 cacheable answer untouched.
// - Tag test read in window captures tag bits 0-7 into low probe.
// - Probe registers have no reset, take bus writes in any mode, and feed tag RAM only in tag test mode.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sccfg_defines.svh"

module sccfg_top
  import sccfg_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output var  logic [31:0]       AVS_READDATA,
  output var  logic              AVS_WAITREQUEST,
  output var  logic [1:0]        AVS_RESPONSE,
  input  wire sccfg_host_t       HOST,
  output var  sccfg_cfg_t        SC_CFG,
  output var  logic              CAS_INHIBIT,
  output var  logic              LINE_FILL_EN,
  output var  logic              HIT_SERVICE,
  output var  logic              L1_CACHEABLE_IN_N,
  output var  logic              TAG_MATCH,
  input  wire logic [10:0]       TAG_DQ_I,
  output var  logic [10:0]       TAG_DQ_O,
  output var  logic              TAG_DQ_OE,
  output var  logic              TAG_WE,
  output var  logic              TAG_RD
);

  localparam int RD_CYC_I = (`SCCFG_TAG_RD_NS * `SCCFG_CLK_MHZ + 999) / 1000;
  localparam int WR_CYC_I = (`SCCFG_TAG_WR_NS * `SCCFG_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RD_CYC = 4'(RD_CYC_I + `SCCFG_SYNC_CYC);
  localparam logic [3:0] WR_CYC = 4'(WR_CYC_I);

  if (ADDR_W < 10) begin : g_chk
    $error("ADDR_W must reach byte address 0x90");
  end

  function automatic sccfg_burst_t wr_burst_of(input logic [1:0] c);
    unique case (c)
      2'h0: wr_burst_of = SCCFG_B2111;
      2'h2: wr_burst_of = SCCFG_B3222;
      2'h3: wr_burst_of = SCCFG_B4222;
      2'h1: wr_burst_of = SCCFG_B4222;
    endcase
  endfunction

  function automatic sccfg_burst_t rd_burst_of(input logic [1:0] c);
    unique case (c)
      2'h0: rd_burst_of = SCCFG_B2111;
      2'h1: rd_burst_of = SCCFG_B2222;
      2'h2: rd_burst_of = SCCFG_B3222;
      2'h3: rd_burst_of = SCCFG_B3222;
    endcase
  endfunction

  function automatic logic [10:0] mask_of(input logic [1:0] w);
    unique case (w)
      2'h1:    mask_of = 11'h1FF;
      2'h2:    mask_of = 11'h7FF;
      default: mask_of = 11'h0FF;
    endcase
  endfunction

  function automatic logic [10:0] tag_of(input logic [31:0] a,
                                         input logic [2:0]  s);
    unique case (s)
      3'h1:    tag_of = a[27:17];
      3'h2:    tag_of = a[28:18];
      3'h3:    tag_of = a[29:19];
      3'h4:    tag_of = a[30:20];
      default: tag_of = a[26:16];
    endcase
  endfunction

  function automatic logic fill_ok(input logic [1:0] sel,
                                   input logic       code);
    unique case (sel)
      2'h1:    fill_ok = code;
      2'h2:    fill_ok = !code;
      default: fill_ok = 1'b1;
    endcase
  endfunction

  // Register bus state
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  resp_q;
  logic [1:0]  resp_d;
  logic [7:0]  mode_q;
  logic [7:0]  mode_d;
  logic [7:0]  geom_q;
  logic [7:0]  geom_d;
  logic [7:0]  diag_q;
  logic [7:0]  diag_d;
  logic [7:0]  prb_lo_q;
  logic [7:0]  prb_lo_d;
  logic [2:0]  prb_hi_q;
  logic [2:0]  prb_hi_d;

  logic [7:0]  idx;
  logic        mapped;
  logic        wr_go;
  logic [7:0]  rd_mux;

  // Tag test state
  sccfg_state_t st_q;
  sccfg_state_t st_d;
  logic [3:0]   cnt_q;
  logic [3:0]   cnt_d;
  logic         we_q;
  logic         we_d;
  logic         oe_q;
  logic         oe_d;
  logic         rd_q;
  logic         rd_d;
  logic [10:0]  wd_q;
  logic [10:0]  wd_d;
  logic         capture;

  // Tag pin synchroniser
  logic [10:0]  s1_q;
  logic [10:0]  s2_q;
  logic [10:0]  s3_q;

  // Host side outputs
  logic         in_win;
  logic         cas_q;
  logic         cas_d;
  logic         fill_q;
  logic         fill_d;
  logic         hitsv_q;
  logic         hitsv_d;
  logic         l1n_q;
  logic         l1n_d;
  logic         match_q;
  logic         match_d;
  sccfg_cfg_t   cfg_q;
  sccfg_cfg_t   cfg_d;

  assign idx = AVS_ADDRESS[9:2];

  always_comb begin
    unique case (idx)
      `SCCFG_IDX_MODE:   rd_mux = mode_q;
      `SCCFG_IDX_GEOM:   rd_mux = geom_q;
      `SCCFG_IDX_DIAG:   rd_mux = diag_q;
      `SCCFG_IDX_PRB_LO: rd_mux = prb_lo_q;
      `SCCFG_IDX_PRB_HI: rd_mux = {5'h00, prb_hi_q};
      default:           rd_mux = 8'h00;
    endcase
    mapped = (idx >= `SCCFG_IDX_MODE) && (idx <= `SCCFG_IDX_PRB_HI);
  end

  // Two-cycle slave: waitrequest drops for one cycle per request
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_d = 1'b0;
      resp_d = mapped ? 2'h0 : 2'h2;
      if (AVS_READ) begin
        rdata_d = {24'h00_0000, rd_mux};
      end
    end
    wr_go = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0] && mapped;
  end

  always_comb begin
    mode_d = mode_q;
    geom_d = geom_q;
    diag_d = diag_q;
    if (wr_go) begin
      unique case (idx)
        `SCCFG_IDX_MODE: mode_d = AVS_WRITEDATA[7:0];
        `SCCFG_IDX_GEOM: geom_d = AVS_WRITEDATA[7:0] & `SCCFG_GEOM_WMASK;
        `SCCFG_IDX_DIAG: diag_d = AVS_WRITEDATA[7:0] & `SCCFG_DIAG_WMASK;
        default: ;
      endcase
    end
  end

  // Captured tag data wins over a bus write in the same cycle
  always_comb begin
    prb_lo_d = prb_lo_q;
    prb_hi_d = prb_hi_q;
    if (capture) begin
      prb_lo_d = s3_q[7:0];
      prb_hi_d = s3_q[10:8];
    end else if (wr_go && idx == `SCCFG_IDX_PRB_LO) begin
      prb_lo_d = AVS_WRITEDATA[7:0];
    end else if (wr_go && idx == `SCCFG_IDX_PRB_HI) begin
      prb_hi_d = 3'(AVS_WRITEDATA[7:0] & `SCCFG_PRB_HI_WMASK);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
      mode_q  <= `SCCFG_MODE_RST;
      geom_q  <= `SCCFG_GEOM_RST;
      diag_q  <= `SCCFG_DIAG_RST;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
      mode_q  <= mode_d;
      geom_q  <= geom_d;
      diag_q  <= diag_d;
    end
  end

  // Probe registers power up undefined
  always_ff @(posedge CLK) begin
    prb_lo_q <= prb_lo_d;
    prb_hi_q <= prb_hi_d;
  end

  sccfg_window u_win (
    .size   (geom_q[`SCCFG_GEOM_SIZE_LSB +: 3]),
    .wsel   (diag_q[`SCCFG_DIAG_WSEL]),
    .addr   (HOST.addr),
    .in_win (in_win)
  );

  // Tag RAM access sequencer for test mode
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    we_d    = we_q;
    oe_d    = oe_q;
    rd_d    = rd_q;
    wd_d    = wd_q;
    capture = 1'b0;
    unique case (st_q)
      SCCFG_IDLE: begin
        if (HOST.valid && in_win && diag_q[`SCCFG_DIAG_TAG]) begin
          cnt_d = HOST.write ? WR_CYC : RD_CYC;
          if (HOST.write) begin
            st_d = SCCFG_WR;
            we_d = 1'b1;
            oe_d = 1'b1;
            wd_d = {prb_hi_q, prb_lo_q};
          end else begin
            st_d = SCCFG_RD;
            rd_d = 1'b1;
          end
        end
      end
      SCCFG_WR: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          st_d = SCCFG_IDLE;
          we_d = 1'b0;
          oe_d = 1'b0;
        end
      end
      SCCFG_RD: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (s2_q == s3_q) begin
          capture = 1'b1;
          st_d    = SCCFG_IDLE;
          rd_d    = 1'b0;
        end
      end
      default: begin
        st_d = SCCFG_IDLE;
        we_d = 1'b0;
        oe_d = 1'b0;
        rd_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q  <= SCCFG_IDLE;
      cnt_q <= 4'h0;
      we_q  <= 1'b0;
      oe_q  <= 1'b0;
      rd_q  <= 1'b0;
      wd_q  <= 11'h000;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      we_q  <= we_d;
      oe_q  <= oe_d;
      rd_q  <= rd_d;
      wd_q  <= wd_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s1_q <= 11'h000;
      s2_q <= 11'h000;
      s3_q <= 11'h000;
    end else begin
      s1_q <= TAG_DQ_I;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Host cycle qualifiers and configuration outputs
  always_comb begin
    cas_d = HOST.valid && HOST.dram && in_win
            && diag_q[`SCCFG_DIAG_SRAM];
    fill_d = HOST.valid && !HOST.write && HOST.cacheable && !HOST.hit
             && mode_q[`SCCFG_MODE_EN] && !mode_q[`SCCFG_MODE_FRZ]
             && fill_ok(diag_q[`SCCFG_DIAG_FILL_LSB +: 2], HOST.code);
    hitsv_d = HOST.valid && HOST.hit && mode_q[`SCCFG_MODE_EN];
    l1n_d   = !HOST.cacheable;
    match_d = ((s3_q ^ tag_of(HOST.addr, geom_q[`SCCFG_GEOM_SIZE_LSB +: 3]))
              & mask_of(geom_q[`SCCFG_GEOM_TAGW_LSB +: 2])) == 11'h000;
    cfg_d.wr_burst   = wr_burst_of(mode_q[`SCCFG_MODE_WRB_LSB +: 2]);
    cfg_d.rd_burst   = rd_burst_of(mode_q[`SCCFG_MODE_RDB_LSB +: 2]);
    cfg_d.tag_mask   = mask_of(geom_q[`SCCFG_GEOM_TAGW_LSB +: 2]);
    cfg_d.size       = geom_q[`SCCFG_GEOM_SIZE_LSB +: 3];
    cfg_d.dual_bank  = geom_q[`SCCFG_GEOM_BANK];
    cfg_d.enable     = mode_q[`SCCFG_MODE_EN];
    cfg_d.write_back = mode_q[`SCCFG_MODE_WB];
    cfg_d.init       = mode_q[`SCCFG_MODE_INIT];
    cfg_d.freeze     = mode_q[`SCCFG_MODE_FRZ];
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cas_q   <= 1'b0;
      fill_q  <= 1'b0;
      hitsv_q <= 1'b0;
      l1n_q   <= 1'b1;
      match_q <= 1'b0;
      cfg_q   <= '0;
    end else begin
      cas_q   <= cas_d;
      fill_q  <= fill_d;
      hitsv_q <= hitsv_d;
      l1n_q   <= l1n_d;
      match_q <= match_d;
      cfg_q   <= cfg_d;
    end
  end

  assign AVS_WAITREQUEST   = wait_q;
  assign AVS_READDATA      = rdata_q;
  assign AVS_RESPONSE      = resp_q;
  assign SC_CFG            = cfg_q;
  assign CAS_INHIBIT       = cas_q;
  assign LINE_FILL_EN      = fill_q;
  assign HIT_SERVICE       = hitsv_q;
  assign L1_CACHEABLE_IN_N = l1n_q;
  assign TAG_MATCH         = match_q;
  assign TAG_DQ_O          = wd_q;
  assign TAG_DQ_OE         = oe_q;
  assign TAG_WE            = we_q;
  assign TAG_RD            = rd_q;

endmodule
`default_nettype wire

// File: shared/sccfg_defines.svh
// Purpose: Offsets, field positions, reset values and timing for the cache config block
// Assumes: Register indexes are scaled by four to form Avalon byte addresses
// Notes:   Definitions only
`ifndef SCCFG_DEFINES_SVH
`define SCCFG_DEFINES_SVH

`define SCCFG_IDX_MODE      8'h20
`define SCCFG_IDX_GEOM      8'h21
`define SCCFG_IDX_DIAG      8'h22
`define SCCFG_IDX_PRB_LO    8'h23
`define SCCFG_IDX_PRB_HI    8'h24

`define SCCFG_MODE_RST      8'h00
`define SCCFG_GEOM_RST      8'h00
`define SCCFG_DIAG_RST      8'h00

`define SCCFG_GEOM_WMASK    8'hF6
`define SCCFG_DIAG_WMASK    8'hCB
`define SCCFG_PRB_HI_WMASK  8'h07

`define SCCFG_MODE_WB       0
`define SCCFG_MODE_INIT     1
`define SCCFG_MODE_FRZ      2
`define SCCFG_MODE_EN       3
`define SCCFG_MODE_WRB_LSB  4
`define SCCFG_MODE_RDB_LSB  6
`define SCCFG_GEOM_TAGW_LSB 1
`define SCCFG_GEOM_SIZE_LSB 4
`define SCCFG_GEOM_BANK     7
`define SCCFG_DIAG_SRAM     0
`define SCCFG_DIAG_TAG      1
`define SCCFG_DIAG_WSEL     3
`define SCCFG_DIAG_FILL_LSB 6

`define SCCFG_WIN_LO_A      32'h0004_0000
`define SCCFG_WIN_HI_A      32'h0007_FFFF
`define SCCFG_WIN_LO_B      32'h0002_0000
`define SCCFG_WIN_HI_B      32'h0009_FFFF
`define SCCFG_WIN_LO_C      32'h0010_0000
`define SCCFG_WIN_HI_C      32'h001F_FFFF

`define SCCFG_CLK_MHZ       200
`define SCCFG_TAG_RD_NS     15
`define SCCFG_TAG_WR_NS     10
`define SCCFG_SYNC_CYC      3

`endif

// File: shared/sccfg_pkg.sv
// Purpose: Types shared by the cache config block
// Assumes: Host cycle fields come from the cache controller on the same clock
// Notes:   Constants live in sccfg_defines.svh
package sccfg_pkg;

  typedef enum logic [1:0] {
    SCCFG_B2111 = 2'h0,
    SCCFG_B2222 = 2'h1,
    SCCFG_B3222 = 2'h2,
    SCCFG_B4222 = 2'h3
  } sccfg_burst_t;

  typedef enum logic [1:0] {
    SCCFG_IDLE = 2'h0,
    SCCFG_RD   = 2'h1,
    SCCFG_WR   = 2'h2
  } sccfg_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        code;
    logic        dram;
    logic        cacheable;
    logic        hit;
    logic [31:0] addr;
  } sccfg_host_t;

  typedef struct packed {
    sccfg_burst_t wr_burst;
    sccfg_burst_t rd_burst;
    logic [10:0]  tag_mask;
    logic [2:0]   size;
    logic         dual_bank;
    logic         enable;
    logic         write_back;
    logic         init;
    logic         freeze;
  } sccfg_cfg_t;

endpackage

// File: rtl/sccfg_window.sv
// Purpose: Decodes whether a host address lies in the diagnostic test window
// Assumes: Size codes above 1M bytes behave as 64K bytes
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "sccfg_defines.svh"

module sccfg_window (
  input  wire logic [2:0]  size,
  input  wire logic        wsel,
  input  wire logic [31:0] addr,
  output var  logic        in_win
);

  logic [31:0] lo;
  logic [31:0] hi;

  always_comb begin
    lo = `SCCFG_WIN_LO_A;
    hi = `SCCFG_WIN_HI_A;
    if (wsel) begin
      lo = `SCCFG_WIN_LO_C;
      hi = `SCCFG_WIN_HI_C;
    end else if (size == 3'h3) begin
      lo = `SCCFG_WIN_LO_B;
      hi = `SCCFG_WIN_HI_B;
    end
    in_win = (addr >= lo) && (addr <= hi);
  end

endmodule
`default_nettype wire

// File: test/sccfg_tag_model.sv
// Purpose: Behavioural tag RAM on the tag pins
// Assumes: One tag entry; answers LAT cycles into a read
// Notes:   Released pins toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module sccfg_tag_model #(
  parameter int LAT = 4
) (
  input  wire logic        clk,
  input  wire logic [10:0] dq_o,
  input  wire logic        oe,
  input  wire logic        we,
  input  wire logic        rd,
  output var  logic [10:0] dq_i
);
  logic [10:0] mem_q;
  logic [10:0] last_q = 11'h000;
  int          cnt_q = 0;
  always_ff @(posedge clk) begin
    if (we && oe) begin
      mem_q <= dq_o;
    end
    cnt_q <= rd ? cnt_q + 1 : 0;
    last_q <= dq_i;
  end
  // Entry shows only after the read settles; driven pins echo dq_o, otherwise they wander
  always_comb begin
    dq_i = oe ? dq_o : (rd && cnt_q >= LAT) ? mem_q : ~last_q;
  end
endmodule
`default_nettype wire

// File: test/sccfg_asserts.sv
// Purpose: Port checks for sccfg_top
// Assumes: Bound into sccfg_top
// Notes:   One clock domain
`timescale 1ns/100ps
`default_nettype none
module sccfg_asserts
  import sccfg_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic        AVS_WAITREQUEST,
  input  wire sccfg_host_t HOST,
  input  wire sccfg_cfg_t  SC_CFG,
  input  wire logic        CAS_INHIBIT,
  input  wire logic        LINE_FILL_EN,
  input  wire logic        HIT_SERVICE,
  input  wire logic        L1_CACHEABLE_IN_N,
  input  wire logic        TAG_DQ_OE,
  input  wire logic        TAG_WE,
  input  wire logic        TAG_RD
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  wait_low_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest not dropped");
  wait_pulse_a: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  wr_code_a: assert property (SC_CFG.wr_burst != SCCFG_B2222)
    else $error("bad write burst");
  rd_code_a: assert property (SC_CFG.rd_burst != SCCFG_B4222)
    else $error("bad read burst");
  tag_mask_a: assert property ($past(RSTN, 2) |-> SC_CFG.tag_mask inside {11'h0FF, 11'h1FF, 11'h7FF})
    else $error("bad tag mask");
  cas_cause_a: assert property (CAS_INHIBIT |-> $past(HOST.valid && HOST.dram))
    else $error("cas inhibit without dram cycle");
  fill_cause_a: assert property (LINE_FILL_EN |-> $past(HOST.valid && !HOST.write && !HOST.hit))
    else $error("fill without read miss");
  hit_serve_a: assert property (HOST.valid && HOST.hit && SC_CFG.enable |=> HIT_SERVICE)
    else $error("hit not serviced");
  l1_follow_a: assert property (HOST.valid |=> L1_CACHEABLE_IN_N == !$past(HOST.cacheable))
    else $error("l1 answer wrong");
  tag_write_a: assert property ($rose(TAG_WE) |-> TAG_DQ_OE ##1 TAG_WE && TAG_DQ_OE ##1 !TAG_WE)
    else $error("tag write strobe wrong");
  tag_read_a: assert property ($rose(TAG_RD) |-> TAG_RD [*6] ##[1:30] !TAG_RD)
    else $error("tag read length wrong");
  rd_quiet_a: assert property (TAG_RD |-> !TAG_DQ_OE)
    else $error("tag pins driven in read");
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: Self-checking bench for sccfg_top
// Assumes: Tag RAM model on the tag pins
// Notes:   Avalon master tasks; one idle cycle between transfers
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sccfg_pkg::*;
;
  logic         CLK = 1'b0;
  logic         RSTN = 1'b0;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [9:0]   adr = 10'h000;
  logic [31:0]  wd = 32'h0;
  logic [31:0]  rdat, q;
  logic [1:0]   resp, r;
  logic         wreq, cas, fill, hit, l1_n, we, oe, trd, tmatch;
  logic [10:0]  dq_o, dq_i;
  sccfg_host_t  host = '0;
  sccfg_cfg_t   cfg;
  int           error_cnt = 0;
  int           checked = 0;
  int           cyc = 0;
  sccfg_burst_t wexp[4] = '{SCCFG_B2111, SCCFG_B4222, SCCFG_B3222, SCCFG_B4222};
  sccfg_burst_t rexp[4] = '{SCCFG_B2111, SCCFG_B2222, SCCFG_B3222, SCCFG_B3222};
  logic [10:0]  mexp[5] = '{11'h0FF, 11'h1FF, 11'h7FF, 11'h0FF, 11'h0FF};
  logic [36:0]  wt[10] = '{{3'h0, 1'b0, 32'h0004_0000, 1'b1}, {3'h0, 1'b0, 32'h0003_FFFF, 1'b0},
    {3'h0, 1'b0, 32'h0007_FFFF, 1'b1}, {3'h0, 1'b0, 32'h0008_0000, 1'b0},
    {3'h3, 1'b0, 32'h0002_0000, 1'b1}, {3'h3, 1'b0, 32'h0009_FFFF, 1'b1},
    {3'h3, 1'b0, 32'h000A_0000, 1'b0}, {3'h2, 1'b1, 32'h0010_0000, 1'b1},
    {3'h2, 1'b1, 32'h001F_FFFF, 1'b1}, {3'h2, 1'b1, 32'h0020_0000, 1'b0}};
  sccfg_top dut (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .AVS_RESPONSE(resp), .HOST(host), .SC_CFG(cfg), .CAS_INHIBIT(cas), .LINE_FILL_EN(fill),
    .HIT_SERVICE(hit), .L1_CACHEABLE_IN_N(l1_n), .TAG_MATCH(tmatch), .TAG_DQ_I(dq_i),
    .TAG_DQ_O(dq_o), .TAG_DQ_OE(oe), .TAG_WE(we), .TAG_RD(trd));
  sccfg_tag_model #(.LAT(4)) ram (.clk(CLK), .dq_o(dq_o), .oe(oe), .we(we), .rd(trd),
    .dq_i(dq_i));
  initial begin
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge CLK);
    wr <= w;
    rd <= !w;
    adr <= {idx, 2'b00};
    wd <= {24'h0, d};
    do @(posedge CLK); while (wreq !== 1'b0);
    q = rdat;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] re);
    bus(1'b0, idx, 8'h00);
    cmp(q, {24'h0, exp});
    cmp(32'(r), 32'(re));
  endtask
  task automatic hcyc(input logic w, c, dr, ca, h, input logic [31:0] a);
    @(posedge CLK);
    host <= {1'b1, w, c, dr, ca, h, a};
    @(posedge CLK);
    host.valid <= 1'b0;
    @(negedge CLK);
    while (trd !== 1'b0 || we !== 1'b0) @(negedge CLK);
  endtask
  initial begin
    logic [7:0] g;
    logic [2:0] k;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    rdchk(8'h20, 8'h00, 2'b00);
    rdchk(8'h21, 8'h00, 2'b00);
    rdchk(8'h22, 8'h00, 2'b00);
    rdchk(8'h25, 8'h00, 2'b10);
    for (int i = 0; i < 4; i++) begin
      k = 3'(i);
      bus(1'b1, 8'h20, {k[1:0], k[1:0], 1'b0, k[0], k[1], k[0]});
      rdchk(8'h20, {k[1:0], k[1:0], 1'b0, k[0], k[1], k[0]}, 2'b00);
      cmp(32'(cfg.wr_burst), 32'(wexp[i]));
      cmp(32'(cfg.rd_burst), 32'(rexp[i]));
      cmp(32'({cfg.freeze, cfg.init, cfg.write_back, cfg.enable}), 32'({k[0], k[1], k[0], 1'b0}));
    end
    for (int i = 0; i < 5; i++) begin
      k = 3'(i);
      g = {k[0], k, 1'b1, k[1:0], 1'b1};
      bus(1'b1, 8'h21, g);
      rdchk(8'h21, g & 8'hF6, 2'b00);
      cmp(32'(cfg.tag_mask), 32'(mexp[i]));
      cmp(32'({cfg.dual_bank, cfg.size}), 32'({k[0], k}));
    end
    bus(1'b1, 8'h22, 8'hFF);
    rdchk(8'h22, 8'hCB, 2'b00);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, 8'h21, {1'b0, wt[i][36:34], 4'h0});
      bus(1'b1, 8'h22, {4'h0, wt[i][33], 3'b001});
      hcyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, wt[i][32:1]);
      cmp(32'(cas), 32'(wt[i][0]));
    end
    bus(1'b1, 8'h22, 8'h00);
    hcyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0010_0000);
    cmp(32'(cas), 32'h0);
    bus(1'b1, 8'h21, 8'h00);
    bus(1'b1, 8'h20, 8'h08);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      bus(1'b1, 8'h22, {k[2:1], 6'h00});
      hcyc(1'b0, k[0], 1'b0, 1'b1, 1'b0, 32'h0000_1000);
      cmp(32'(fill), 32'(k[2:1] == 2'b00 || k[2:1] == 2'b11 || k[2] != k[0]));
      hcyc(1'b0, k[0], 1'b0, 1'b1, 1'b1, 32'h0000_1000);
      cmp(32'({hit, l1_n}), 32'h2);
    end
    hcyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_1000);
    cmp(32'(l1_n), 32'h1);
    bus(1'b1, 8'h22, 8'h02);
    bus(1'b1, 8'h23, 8'h5A);
    bus(1'b1, 8'h24, 8'hFD);
    rdchk(8'h24, 8'h05, 2'b00);
    hcyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0004_0000);
    bus(1'b1, 8'h23, 8'h00);
    bus(1'b1, 8'h24, 8'h00);
    hcyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0004_0000);
    cmp(32'(tmatch), 32'h0);
    rdchk(8'h23, 8'h5A, 2'b00);
    rdchk(8'h24, 8'h05, 2'b00);
    bus(1'b1, 8'h23, 8'h04);
    hcyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0004_0000);
    hcyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0004_0000);
    cmp(32'(tmatch), 32'h1);
    bus(1'b1, 8'h22, 8'h00);
    bus(1'b1, 8'h23, 8'h33);
    hcyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0004_0000);
    rdchk(8'h23, 8'h33, 2'b00);
    test_done();
  end
endmodule
bind sccfg_top sccfg_asserts u_chk (.CLK(CLK), .RSTN(RSTN), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HOST(HOST), .SC_CFG(SC_CFG),
  .CAS_INHIBIT(CAS_INHIBIT), .LINE_FILL_EN(LINE_FILL_EN), .HIT_SERVICE(HIT_SERVICE),
  .L1_CACHEABLE_IN_N(L1_CACHEABLE_IN_N), .TAG_DQ_OE(TAG_DQ_OE), .TAG_WE(TAG_WE),
  .TAG_RD(TAG_RD));
`default_nettype wire
